// File: fpoc_defines.vh
// Constants shared by the flash power-down, OTP and protection command block
`ifndef FPOC_DEFINES_VH
`define FPOC_DEFINES_VH

// Opcodes taken from the command set
`define FPOC_OP_WRITE_ENABLE 8'h06
`define FPOC_OP_OTP_ENTER 8'hB1
`define FPOC_OP_OTP_EXIT 8'hC1
`define FPOC_OP_SINGLE_LOCK 8'h36
`define FPOC_OP_SINGLE_UNLOCK 8'h39
`define FPOC_OP_CHIP_UNLOCK 8'h98

// Opcodes with no known value; arbitrary defaults, overridable by parameter
`define FPOC_OP_DEEP_SLEEP 8'hD1
`define FPOC_OP_SLEEP_RELEASE 8'hD2
`define FPOC_OP_SECREG_READ 8'hD3
`define FPOC_OP_SECREG_WRITE 8'hD4
`define FPOC_OP_PROTECT_SELECT 8'hD5

// Frame bit counts
`define FPOC_CNT_W 6
`define FPOC_CNT_ZERO 6'h00
`define FPOC_CNT_MAX 6'h3F
`define FPOC_OP_BITS 6'h08
`define FPOC_ADDR_BITS 6'h20
`define FPOC_STEP_SPI 6'h01
`define FPOC_STEP_QPI 6'h04
`define FPOC_RDP_SPI 3'h1
`define FPOC_RDP_QPI 3'h4

// Security register bit positions
`define FPOC_SR_FACTORY 0
`define FPOC_SR_CUST_LOCK 1
`define FPOC_SR_PROG_PAUSED 2
`define FPOC_SR_ERASE_PAUSED 3
`define FPOC_SR_RESERVED 4
`define FPOC_SR_PROG_FAIL 5
`define FPOC_SR_ERASE_FAIL 6
`define FPOC_SR_METHOD 7
`define FPOC_SR_RESET 8'h00

// Block addressing: 128 blocks of 64 KB
`define FPOC_BLOCKS 128
`define FPOC_BLK_LSB 16
`define FPOC_BLK_MSB 22
`define FPOC_BLK_ALL 7'h7F
`define FPOC_BLK_ONE 7'h01
`define FPOC_BP_ALL 4'h8
`define FPOC_BP_NONE 4'h0
`define FPOC_BP_ONE 4'h1

// Power-down entry delay: 3000 ns at a 10 ns clock
`define FPOC_TDP_CYC 12'h12C
`define FPOC_TDP_W 12
`define FPOC_TDP_ZERO 12'h000
`define FPOC_TDP_ONE 12'h001

// Pin sync reset value: chip select idle high, clock and data low
`define FPOC_PIN_RST 6'h20

`endif

// File: fpoc_sync.v
// Two-flop synchroniser for the serial pins
`timescale 1ns/10ps
module fpoc_sync #(
  parameter W = 6,
  parameter [W-1:0] RV = {W{1'b0}}
) (
  // Clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // Data
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);

  reg [W-1:0] meta_q;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RV;
      q_o <= RV;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

// File: fpoc_blklock.v
// Per-block volatile lock bits
`timescale 1ns/10ps
`include "fpoc_defines.vh"
module fpoc_blklock (
  // Clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // Commands
  input wire lock_i,
  input wire unlock_i,
  input wire all_unlock_i,
  input wire [6:0] idx_i,
  // Lock state
  output wire [`FPOC_BLOCKS-1:0] lock_o
);

  genvar i;
  generate
    for (i = 0; i < `FPOC_BLOCKS; i = i + 1) begin : g_blk
      reg lock_q;
      always @(posedge mclk_i or negedge rstn_i) begin
        // All blocks come up locked
        if (!rstn_i) begin
          lock_q <= 1'b1;
        end else if (all_unlock_i) begin
          lock_q <= 1'b0;
        end else if (lock_i && idx_i == i[6:0]) begin
          lock_q <= 1'b1;
        end else if (unlock_i && idx_i == i[6:0]) begin
          lock_q <= 1'b0;
        end
      end
      assign lock_o[i] = lock_q;
    end
  endgenerate

endmodule

// File: fpoc_ctrl.v
// Command handling for deep power-down, secured OTP, security register and protection select
`timescale 1ns/10ps
`include "fpoc_defines.vh"
module fpoc_ctrl #(
  parameter [7:0] DEEP_SLEEP_OP = `FPOC_OP_DEEP_SLEEP,
  parameter [7:0] SLEEP_RELEASE_OP = `FPOC_OP_SLEEP_RELEASE,
  parameter [7:0] OTP_ENTER_OP = `FPOC_OP_OTP_ENTER,
  parameter [7:0] OTP_EXIT_OP = `FPOC_OP_OTP_EXIT,
  parameter [7:0] SECREG_READ_OP = `FPOC_OP_SECREG_READ,
  parameter [7:0] SECREG_WRITE_OP = `FPOC_OP_SECREG_WRITE,
  parameter [7:0] PROTECT_SELECT_OP = `FPOC_OP_PROTECT_SELECT
) (
  // Clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // Serial pins
  input wire cs_n_i,
  input wire sclk_i,
  input wire [3:0] sio_i,
  output reg [3:0] sio_o,
  output reg [3:0] sio_oe_o,
  // Device mode and engine state
  input wire quad_command_mode_i,
  input wire [3:0] block_protect_bits_i,
  input wire program_paused_flag_i,
  input wire erase_paused_flag_i,
  input wire program_fail_i,
  input wire erase_fail_i,
  // Non-volatile bits as stored
  input wire nv_factory_lock_i,
  input wire nv_otp_customer_lock_i,
  input wire nv_protect_method_i,
  // Protection query
  input wire [23:0] prot_addr_i,
  output reg prot_o,
  // Status to the rest of the device
  output reg [7:0] secreg_o,
  output reg deep_sleep_o,
  output reg otp_mode_o,
  output reg array_block_o,
  output reg status_write_ok_o,
  output reg otp_write_ok_o,
  output reg write_enable_o
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PDWAIT = 3'b010;
  localparam [2:0] ST_SLEEP = 3'b100;
  localparam [`FPOC_TDP_W-1:0] TDP_CYC = `FPOC_TDP_CYC;

  wire [5:0] pin_s;
  wire cs_s = pin_s[5];
  wire sck_s = pin_s[4];
  wire [3:0] sio_s = pin_s[3:0];

  reg cs_d_q;
  reg sck_d_q;
  reg [`FPOC_CNT_W-1:0] cnt_q;
  reg [`FPOC_CNT_W-1:0] cnt_d;
  reg [31:0] sh_q;
  reg [31:0] sh_d;
  reg [7:0] op_q;
  reg opv_q;
  reg [2:0] rdp_q;
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [`FPOC_TDP_W-1:0] tdp_q;
  reg otp_q;
  reg wel_q;
  reg lock_set_q;
  reg method_set_q;
  reg [7:0] secreg_q;
  reg [6:0] bp_mask;
  reg bp_prot;

  wire [`FPOC_BLOCKS-1:0] blk_lock;

  // Pins cross into the clock domain
  fpoc_sync #(
    .W(6),
    .RV(`FPOC_PIN_RST)
  ) u_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .d_i({cs_n_i, sclk_i, sio_i}),
    .q_o(pin_s)
  );

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_d_q <= 1'b1;
      sck_d_q <= 1'b0;
    end else begin
      cs_d_q <= cs_s;
      sck_d_q <= sck_s;
    end
  end

  wire cs_rise = cs_s & ~cs_d_q;
  wire sck_rise = ~cs_s & sck_s & ~sck_d_q;
  wire sck_fall = ~cs_s & ~sck_s & sck_d_q;
  wire awake = st_q[0];

  // Shift in one line per clock, or four in quad form
  always @* begin
    if (quad_command_mode_i) begin
      sh_d = {sh_q[27:0], sio_s};
      cnt_d = (cnt_q > `FPOC_CNT_MAX - `FPOC_STEP_QPI) ? `FPOC_CNT_MAX : cnt_q + `FPOC_STEP_QPI;
    end else begin
      sh_d = {sh_q[30:0], sio_s[0]};
      cnt_d = (cnt_q == `FPOC_CNT_MAX) ? `FPOC_CNT_MAX : cnt_q + `FPOC_STEP_SPI;
    end
  end

  wire is_dp = (op_q == DEEP_SLEEP_OP);
  wire is_rdp = (op_q == SLEEP_RELEASE_OP);
  wire is_otp_enter_cmd = (op_q == OTP_ENTER_OP);
  wire is_otp_exit_cmd = (op_q == OTP_EXIT_OP);
  wire is_rdsr = (op_q == SECREG_READ_OP);
  wire is_status_write_cmd = (op_q == SECREG_WRITE_OP);
  wire is_psel = (op_q == PROTECT_SELECT_OP);
  wire is_write_enable_cmd = (op_q == `FPOC_OP_WRITE_ENABLE);
  wire is_slk = (op_q == `FPOC_OP_SINGLE_LOCK);
  wire is_sulk = (op_q == `FPOC_OP_SINGLE_UNLOCK);
  wire is_culk = (op_q == `FPOC_OP_CHIP_UNLOCK);

  // Commands other than the read act only when chip select rises after exactly 8 bits, or 32 for single-block lock and unlock
  wire ex8 = cs_rise & opv_q & awake & (cnt_q == `FPOC_OP_BITS);
  wire ex32 = cs_rise & opv_q & awake & (cnt_q == `FPOC_ADDR_BITS);
  wire rd_act = opv_q & is_rdsr & awake;

  wire cust_lock = nv_otp_customer_lock_i | lock_set_q;
  wire method = nv_protect_method_i | method_set_q;
  wire status_write_cmd_ok = ex8 & is_status_write_cmd & wel_q & ~otp_q & ~cust_lock;
  wire blk_cmd_ok = method & wel_q;
  wire do_lock = ex32 & is_slk & blk_cmd_ok;
  wire do_unlock = ex32 & is_sulk & blk_cmd_ok;
  wire do_all_unlock = ex8 & is_culk & blk_cmd_ok;

  // Frame capture and read pointer
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= `FPOC_CNT_ZERO;
      sh_q <= 32'h00000000;
      op_q <= 8'h00;
      opv_q <= 1'b0;
      rdp_q <= 3'h0;
    end else if (cs_s) begin
      cnt_q <= `FPOC_CNT_ZERO;
      opv_q <= 1'b0;
      rdp_q <= 3'h0;
    end else if (sck_rise) begin
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      if (cnt_d == `FPOC_OP_BITS && !opv_q) begin
        op_q <= sh_d[7:0];
        opv_q <= 1'b1;
      end
    end else if (sck_fall && rd_act) begin
      rdp_q <= rdp_q + (quad_command_mode_i ? `FPOC_RDP_QPI : `FPOC_RDP_SPI);
    end
  end

  // Security register driven out on falling clock, repeating each byte
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sio_o <= 4'h0;
      sio_oe_o <= 4'h0;
    end else if (cs_s) begin
      sio_oe_o <= 4'h0;
    end else if (sck_fall && rd_act) begin
      if (quad_command_mode_i) begin
        sio_o <= rdp_q[2] ? secreg_q[3:0] : secreg_q[7:4];
        sio_oe_o <= 4'hF;
      end else begin
        sio_o <= {2'b00, secreg_q[~rdp_q], 1'b0};
        sio_oe_o <= 4'h2;
      end
    end
  end

  // Power state
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (ex8 && is_dp) begin
          st_d = ST_PDWAIT;
        end
      end
      ST_PDWAIT: begin
        if (tdp_q == TDP_CYC) begin
          st_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (cs_rise && opv_q && is_rdp && cnt_q == `FPOC_OP_BITS) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= ST_IDLE;
      tdp_q <= `FPOC_TDP_ZERO;
    end else begin
      st_q <= st_d;
      if (st_q == ST_PDWAIT) begin
        tdp_q <= tdp_q + `FPOC_TDP_ONE;
      end else begin
        tdp_q <= `FPOC_TDP_ZERO;
      end
    end
  end

  // OTP mode, write enable and one-way security bits
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      otp_q <= 1'b0;
      wel_q <= 1'b0;
      lock_set_q <= 1'b0;
      method_set_q <= 1'b0;
    end else begin
      if (ex8 && is_otp_enter_cmd) begin
        otp_q <= 1'b1;
      end else if (ex8 && is_otp_exit_cmd) begin
        otp_q <= 1'b0;
      end
      if (ex8 && is_write_enable_cmd) begin
        wel_q <= 1'b1;
      end else if (status_write_cmd_ok || do_lock || do_unlock || do_all_unlock) begin
        wel_q <= 1'b0;
      end
      if (status_write_cmd_ok) begin
        lock_set_q <= 1'b1;
      end
      if (ex8 && is_psel) begin
        method_set_q <= 1'b1;
      end
    end
  end

  fpoc_blklock u_blklock (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .lock_i(do_lock),
    .unlock_i(do_unlock),
    .all_unlock_i(do_all_unlock),
    .idx_i(sh_q[`FPOC_BLK_MSB:`FPOC_BLK_LSB]),
    .lock_o(blk_lock)
  );

  // Block-protect bits cover the top 2^(n-1) blocks
  always @* begin
    bp_mask = (`FPOC_BLK_ONE << (block_protect_bits_i - `FPOC_BP_ONE)) - `FPOC_BLK_ONE;
    if (block_protect_bits_i >= `FPOC_BP_ALL) begin
      bp_prot = 1'b1;
    end else if (block_protect_bits_i == `FPOC_BP_NONE) begin
      bp_prot = 1'b0;
    end else begin
      bp_prot = ((prot_addr_i[`FPOC_BLK_MSB:`FPOC_BLK_LSB] | bp_mask) == `FPOC_BLK_ALL);
    end
  end

  // Registered outputs
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      secreg_q <= `FPOC_SR_RESET;
      secreg_o <= `FPOC_SR_RESET;
      prot_o <= 1'b1;
      deep_sleep_o <= 1'b0;
      otp_mode_o <= 1'b0;
      array_block_o <= 1'b0;
      status_write_ok_o <= 1'b1;
      otp_write_ok_o <= 1'b0;
      write_enable_o <= 1'b0;
    end else begin
      secreg_q[`FPOC_SR_FACTORY] <= nv_factory_lock_i;
      secreg_q[`FPOC_SR_CUST_LOCK] <= cust_lock;
      secreg_q[`FPOC_SR_PROG_PAUSED] <= program_paused_flag_i;
      secreg_q[`FPOC_SR_ERASE_PAUSED] <= erase_paused_flag_i;
      secreg_q[`FPOC_SR_RESERVED] <= 1'b0;
      secreg_q[`FPOC_SR_PROG_FAIL] <= program_fail_i;
      secreg_q[`FPOC_SR_ERASE_FAIL] <= erase_fail_i;
      secreg_q[`FPOC_SR_METHOD] <= method;
      secreg_o <= secreg_q;
      prot_o <= method ? blk_lock[prot_addr_i[`FPOC_BLK_MSB:`FPOC_BLK_LSB]] : bp_prot;
      deep_sleep_o <= st_d[2];
      otp_mode_o <= otp_q;
      array_block_o <= otp_q;
      status_write_ok_o <= ~otp_q;
      otp_write_ok_o <= otp_q & ~cust_lock & ~nv_factory_lock_i;
      write_enable_o <= wel_q;
    end
  end

endmodule

// File: fpoc_ctrl_checker.sv
// Assertions on the power-down, OTP and protection command block
`timescale 1ns/10ps
module fpoc_ctrl_checker (
  // Clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // Watched ports
  input wire cs_n_i,
  input wire [3:0] sio_oe_o,
  input wire [7:0] secreg_o,
  input wire deep_sleep_o,
  input wire otp_mode_o,
  input wire array_block_o,
  input wire status_write_ok_o,
  input wire otp_write_ok_o,
  input wire program_paused_flag_i,
  input wire erase_paused_flag_i,
  input wire program_fail_i,
  input wire erase_fail_i
);
  reg [8:0] idle_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Cycles since chip select was last low
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      idle_q <= 9'h000;
    else if (!cs_n_i)
      idle_q <= 9'h000;
    else if (idle_q != 9'h1FF)
      idle_q <= idle_q + 9'h001;
  end
  sequence cs_idle;
    cs_n_i [*8];
  endsequence
  sequence sleep_rise;
    !deep_sleep_o ##1 deep_sleep_o;
  endsequence
  otp_blk_a: assert property (array_block_o == otp_mode_o)
    else $error("array block differs from OTP mode");
  otp_wr_a: assert property (otp_mode_o |-> !status_write_ok_o)
    else $error("status write allowed in OTP mode");
  otp_ok_a: assert property (otp_write_ok_o |-> otp_mode_o)
    else $error("OTP write allowed outside OTP mode");
  rsv_zero_a: assert property (secreg_o[4] == 1'b0)
    else $error("reserved bit set");
  flag_copy_a: assert property (secreg_o[6:5] == {$past(erase_fail_i, 2), $past(program_fail_i, 2)}
    && secreg_o[3:2] == {$past(erase_paused_flag_i, 2), $past(program_paused_flag_i, 2)})
    else $error("engine flags not mirrored");
  sleep_wait_a: assert property (sleep_rise |-> idle_q >= 9'h12C)
    else $error("deep sleep entered too early");
  lock_keep_a: assert property (!$fell(secreg_o[1]))
    else $error("customer lock cleared");
  method_keep_a: assert property (!$fell(secreg_o[7]))
    else $error("method bit cleared");
  sleep_quiet_a: assert property (deep_sleep_o |-> sio_oe_o == 4'h0)
    else $error("data driven in deep sleep");
  oe_idle_a: assert property (cs_idle |-> sio_oe_o == 4'h0)
    else $error("data driven while deselected");
endmodule
bind fpoc_ctrl fpoc_ctrl_checker chk (.mclk_i, .rstn_i, .cs_n_i, .sio_oe_o, .secreg_o, .deep_sleep_o,
  .otp_mode_o, .array_block_o, .status_write_ok_o, .otp_write_ok_o, .program_paused_flag_i,
  .erase_paused_flag_i, .program_fail_i, .erase_fail_i);

// File: fpoc_host.sv
// Host controller model driving chip select, serial clock and data lines
`timescale 1ns/10ps
module fpoc_host (
  // Clock
  input wire mclk_i,
  // Serial pins
  output reg cs_n_o,
  output reg sclk_o,
  output reg [3:0] sio_o,
  input wire [3:0] sio_i
);
  reg [15:0] rd_q;
  reg [15:0] rq_q;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sio_o = 4'h5;
    rd_q = 16'h0000;
    rq_q = 16'h0000;
  end
  task hc(input integer n);
    begin
      repeat (n) @(posedge mclk_i);
    end
  endtask
  // One 160 ns serial clock; read data taken at the rise
  task clk1(input [3:0] v);
    begin
      sio_o <= v;
      hc(8);
      sclk_o <= 1'b1;
      rd_q <= {rd_q[14:0], sio_i[1]};
      rq_q <= {rq_q[11:0], sio_i};
      hc(8);
      sclk_o <= 1'b0;
    end
  endtask
  // Unused lines keep toggling so stale values never look valid
  task frame(input [7:0] op, input q, input integer n, input [23:0] a);
    integer i;
    begin
      hc(1);
      cs_n_o <= 1'b0;
      if (q) begin
        clk1(op[7:4]);
        clk1(op[3:0]);
      end else begin
        for (i = 7; i >= 0; i = i - 1)
          clk1({~sio_o[3:1], op[i]});
      end
      for (i = 0; i < n; i = i + 1)
        clk1({~sio_o[3:1], a[23 - i]});
      hc(8);
      cs_n_o <= 1'b1;
      sio_o <= ~sio_o;
      hc(12);
    end
  endtask
endmodule

// File: fpoc_ctrl_bench.sv
// Self-checking bench for the power-down, OTP and protection command block
`timescale 1ns/10ps
`include "fpoc_defines.vh"
module fpoc_ctrl_bench;
  reg mclk = 1'b0;
  reg rstn = 1'b0;
  reg quad = 1'b0;
  reg fac = 1'b0;
  reg [3:0] bp = 4'h8;
  reg [3:0] eng = 4'h0;
  reg [23:0] pa = 24'h000000;
  reg nvl = 1'b0;
  reg nvm = 1'b0;
  reg [31:0] r;
  reg [7:0] v;
  reg [10:0] e;
  reg [10:0] exp_q[$];
  integer bad_count = 0;
  integer cmp_count = 0;
  wire cs_n, sclk, ds_o, om, ab, swok, owok, wel, prot;
  wire [3:0] hs, ds, doe, sw;
  wire [7:0] sr;
  assign sw = (doe & ds) | (~doe & hs);
  always #5 mclk = ~mclk;
  fpoc_host host (.mclk_i(mclk), .cs_n_o(cs_n), .sclk_o(sclk), .sio_o(hs), .sio_i(sw));
  fpoc_ctrl DUT (.mclk_i(mclk), .rstn_i(rstn), .cs_n_i(cs_n), .sclk_i(sclk), .sio_i(sw), .sio_o(ds),
    .sio_oe_o(doe), .quad_command_mode_i(quad), .block_protect_bits_i(bp), .program_paused_flag_i(eng[0]),
    .erase_paused_flag_i(eng[1]), .program_fail_i(eng[2]), .erase_fail_i(eng[3]), .nv_factory_lock_i(fac),
    .nv_otp_customer_lock_i(nvl), .nv_protect_method_i(nvm), .prot_addr_i(pa), .prot_o(prot),
    .secreg_o(sr), .deep_sleep_o(ds_o), .otp_mode_o(om), .array_block_o(ab), .status_write_ok_o(swok),
    .otp_write_ok_o(owok), .write_enable_o(wel));
  function [7:0] obs(input [2:0] s);
    case (s)
      3'h0: obs = sr;
      3'h1: obs = {1'b0, ds_o, om, ab, swok, owok, wel, prot};
      3'h2: obs = host.rd_q[15:8];
      3'h3: obs = host.rd_q[7:0];
      3'h4: obs = host.rq_q[15:8];
      3'h6: obs = host.rq_q[7:0];
      default: obs = {4'h0, om, ab, swok, owok};
    endcase
  endfunction
  task note(input [2:0] s, input [7:0] x);
    begin
      exp_q.push_back({s, x});
    end
  endtask
  task cmp(input [7:0] g, input [7:0] x);
    begin
      cmp_count = cmp_count + 1;
      if (g !== x) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task close_out;
    begin
      if (bad_count == 0 && cmp_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task f(input [7:0] op, input q, input integer n, input [23:0] a);
    begin
      host.frame(op, q, n, a);
    end
  endtask
  task rst;
    begin
      @(posedge mclk) rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
    end
  endtask
  task setp(input [3:0] b, input [23:0] a);
    begin
      @(posedge mclk) bp <= b;
      pa <= a;
      repeat (3) @(posedge mclk);
    end
  endtask
  // Stored one-way bits follow the register, as their non-volatile owner would
  always @(posedge mclk) begin
    if (rstn) begin
      nvl <= nvl | sr[1];
      nvm <= nvm | sr[7];
    end
  end
  // Notes are checked one per cycle where outputs have settled
  always @(negedge mclk) begin
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      cmp(obs(e[10:8]), e[7:0]);
    end
  end
  initial begin
    #600000;
    bad_count = bad_count + 1;
    close_out;
  end
  initial begin
    void'($urandom(32'h1B9B));
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    note(1, 8'h09);
    note(0, 8'h00);
    r = $urandom;
    @(posedge mclk) eng <= r[3:0];
    fac <= r[4];
    repeat (4) @(posedge mclk);
    v = {1'b0, r[3], r[2], 1'b0, r[1], r[0], 1'b0, r[4]};
    note(0, v);
    f(`FPOC_OP_SECREG_READ, 1'b0, 16, 24'h0);
    note(2, v);
    note(3, v);
    @(posedge mclk) quad <= 1'b1;
    f(`FPOC_OP_SECREG_READ, 1'b1, 4, 24'h0);
    note(4, v);
    note(6, v);
    @(posedge mclk) eng <= 4'h0;
    fac <= 1'b0;
    quad <= 1'b0;
    f(`FPOC_OP_DEEP_SLEEP, 1'b0, 1, 24'h0);
    repeat (320) @(posedge mclk);
    note(1, 8'h09);
    @(posedge mclk) quad <= 1'b1;
    f(`FPOC_OP_DEEP_SLEEP, 1'b1, 0, 24'h0);
    repeat (100) @(posedge mclk);
    note(1, 8'h09);
    repeat (220) @(posedge mclk);
    note(1, 8'h49);
    f(`FPOC_OP_SECREG_READ, 1'b1, 2, 24'h0);
    f(`FPOC_OP_OTP_ENTER, 1'b1, 0, 24'h0);
    note(1, 8'h49);
    f(`FPOC_OP_SLEEP_RELEASE, 1'b1, 0, 24'h0);
    note(1, 8'h09);
    @(posedge mclk) quad <= 1'b0;
    f(`FPOC_OP_DEEP_SLEEP, 1'b0, 0, 24'h0);
    repeat (320) @(posedge mclk);
    note(1, 8'h49);
    rst;
    note(1, 8'h09);
    f(`FPOC_OP_OTP_ENTER, 1'b0, 0, 24'h0);
    note(5, 8'h0D);
    f(`FPOC_OP_WRITE_ENABLE, 1'b0, 0, 24'h0);
    f(`FPOC_OP_SECREG_WRITE, 1'b0, 0, 24'h0);
    note(0, 8'h00);
    f(`FPOC_OP_OTP_EXIT, 1'b0, 0, 24'h0);
    note(5, 8'h02);
    rst;
    f(`FPOC_OP_SECREG_WRITE, 1'b0, 0, 24'h0);
    note(0, 8'h00);
    f(`FPOC_OP_WRITE_ENABLE, 1'b0, 0, 24'h0);
    note(1, 8'h0B);
    f(`FPOC_OP_SECREG_WRITE, 1'b0, 1, 24'h0);
    note(0, 8'h00);
    f(`FPOC_OP_WRITE_ENABLE, 1'b0, 0, 24'h0);
    f(`FPOC_OP_SECREG_WRITE, 1'b0, 0, 24'h0);
    note(0, 8'h02);
    f(`FPOC_OP_OTP_ENTER, 1'b0, 0, 24'h0);
    note(5, 8'h0C);
    rst;
    note(0, 8'h02);
    setp(4'h1, 24'h7F0000);
    note(1, 8'h09);
    setp(4'h1, 24'h000000);
    note(1, 8'h08);
    f(`FPOC_OP_PROTECT_SELECT, 1'b0, 0, 24'h0);
    note(0, 8'h82);
    note(1, 8'h09);
    f(`FPOC_OP_WRITE_ENABLE, 1'b0, 0, 24'h0);
    f(`FPOC_OP_SINGLE_UNLOCK, 1'b0, 24, 24'h050000);
    setp(4'h1, 24'h05ABCD);
    note(1, 8'h08);
    setp(4'h1, 24'h060000);
    note(1, 8'h09);
    f(`FPOC_OP_WRITE_ENABLE, 1'b0, 0, 24'h0);
    f(`FPOC_OP_SINGLE_LOCK, 1'b0, 24, 24'h050000);
    setp(4'h1, 24'h050000);
    note(1, 8'h09);
    f(`FPOC_OP_WRITE_ENABLE, 1'b0, 0, 24'h0);
    f(`FPOC_OP_CHIP_UNLOCK, 1'b0, 0, 24'h0);
    setp(4'h8, 24'h000000);
    note(1, 8'h08);
    repeat (5) @(posedge mclk);
    close_out;
  end
endmodule
